/* File: logic/lucb_pkg.sv */
package lucb_pkg;

  // Index of the unit-select register and of the per-unit bank registers
  localparam logic [7:0] IDX_UNIT_SEL  = 8'h07;
  localparam logic [7:0] IDX_BANK_LO   = 8'h30;
  localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
  localparam logic [7:0] IDX_BASE_HI   = 8'h60;
  localparam logic [7:0] IDX_BASE_LO   = 8'h61;
  localparam logic [7:0] IDX_BASE2_HI  = 8'h62;
  localparam logic [7:0] IDX_BASE2_LO  = 8'h63;
  localparam logic [7:0] IDX_IRQ1      = 8'h70;
  localparam logic [7:0] IDX_IRQ2      = 8'h72;
  localparam logic [7:0] IDX_DMA       = 8'h74;
  localparam logic [7:0] RD_ZERO       = 8'h00;
  localparam logic [15:0] DATA_PORT_OFS = 16'h0001;
  localparam int unsigned ACT_BIT      = 0;

  // Slot layout: one slot per implemented unit number
  localparam logic [2:0] SLOT_KBD     = 3'h4;
  localparam logic [2:0] SLOT_SERIAL2 = 3'h3;
  localparam logic [7:0] BASE1_MASK   = 8'hEF;
  localparam logic [7:0] BASE2_MASK   = 8'h08;
  localparam logic [7:0] IRQ2_MASK    = 8'h10;
  localparam logic [7:0] DMA_MASK     = 8'h0B;

  // Reset values, slot 7 in the top byte
  localparam logic [7:0][7:0] IRQ1_RST = 64'h0000_0000_0000_0006;
  localparam logic [7:0][7:0] DMA_RST  = 64'h0000_0000_0400_0402;

  // Permitted base ranges and decoded address bits, slot 7 first
  localparam logic [7:0][11:0] RNG_MIN = 96'h100_000_100_060_100_100_100_100;
  localparam logic [7:0][11:0] RNG_MAX = 96'hFFE_F7F_FFF_060_FF8_FF8_FFC_FF8;
  localparam logic [7:0][11:0] RNG_ALN = 96'hFFE_F80_FFF_FFB_FF8_FF8_FFC_FF8;
  localparam logic [15:0]      KBD_BASE = 16'h0060;

  typedef struct packed {
    logic [7:0]      index;
    logic [7:0]      unit_sel;
    logic [7:0]      act;
    logic [7:0][7:0] base_hi;
    logic [7:0][7:0] base_lo;
    logic [7:0][7:0] base2_hi;
    logic [7:0][7:0] base2_lo;
    logic [7:0][7:0] irq1;
    logic [7:0][7:0] irq2;
    logic [7:0][7:0] dma;
    logic [7:0]      rdata;
    logic            rd_ack;
    logic [7:0]      hit;
    logic [7:0]      base_ok;
    logic            irq_edge;
  } lucb_state_s;

  // Unit number to slot; bit 3 flags an implemented unit
  function automatic logic [3:0] lucb_slot(input logic [7:0] num);
    case (num)
      8'h00:   lucb_slot = 4'h8;
      8'h03:   lucb_slot = 4'h9;
      8'h04:   lucb_slot = 4'hA;
      8'h05:   lucb_slot = 4'hB;
      8'h07:   lucb_slot = 4'hC;
      8'h09:   lucb_slot = 4'hD;
      8'h0A:   lucb_slot = 4'hE;
      8'h0B:   lucb_slot = 4'hF;
      default: lucb_slot = 4'h0;
    endcase
  endfunction

endpackage

/* File: logic/lucb_addr_match.sv */
`timescale 1ns/1ps
module lucb_addr_match
  import lucb_pkg::*;
(
  // Programmed base and unit state
  input  wire logic [15:0] base,
  input  wire logic        active,
  input  wire logic [11:0] rng_min,
  input  wire logic [11:0] rng_max,
  input  wire logic [11:0] rng_aln,
  // Host cycle
  input  wire logic        qual16,
  input  wire logic [15:0] io_addr,
  // Decode results
  output logic             base_ok,
  output logic             hit
);

  // Base must sit inside the unit's range and on its boundary
  always_comb begin
    base_ok = (base[15:12] == 4'h0) && (base[11:0] >= rng_min) &&
              (base[11:0] <= rng_max) && ((base[11:0] & ~rng_aln) == 12'h000);
  end

  // Low twelve bits decode; upper four only with 16-bit qualification
  always_comb begin
    hit = active && base_ok &&
          ((io_addr[11:0] & rng_aln) == (base[11:0] & rng_aln)) &&
          (!qual16 || (io_addr[15:12] == 4'h0));
  end

endmodule

/* File: logic/lucb_bank_rd.sv */
`timescale 1ns/1ps
module lucb_bank_rd
  import lucb_pkg::*;
(
  // Selected bank
  input  wire logic [2:0] slot,
  input  wire logic [7:0] index,
  input  wire logic       act,
  input  wire logic [7:0] base_hi,
  input  wire logic [7:0] base_lo,
  input  wire logic [7:0] base2_hi,
  input  wire logic [7:0] base2_lo,
  input  wire logic [7:0] irq1,
  input  wire logic [7:0] irq2,
  input  wire logic [7:0] dma,
  // Read data
  output logic [7:0]      rdata
);

  // Absent or reserved locations read as zero
  always_comb begin
    case (index)
      IDX_ACTIVATE: rdata = {7'h00, act};
      IDX_BASE_HI:  rdata = BASE1_MASK[slot] ? base_hi : RD_ZERO;
      IDX_BASE_LO:  rdata = BASE1_MASK[slot] ? base_lo : RD_ZERO;
      IDX_BASE2_HI: rdata = BASE2_MASK[slot] ? base2_hi : RD_ZERO;
      IDX_BASE2_LO: rdata = BASE2_MASK[slot] ? base2_lo : RD_ZERO;
      IDX_IRQ1:     rdata = irq1;
      IDX_IRQ2:     rdata = IRQ2_MASK[slot] ? irq2 : RD_ZERO;
      IDX_DMA:      rdata = DMA_MASK[slot] ? dma : RD_ZERO;
      default:      rdata = RD_ZERO;
    endcase
  end

endmodule

/* File: logic/lucb_top.sv */
// Functional notes
// - Each unit owns a register bank, picked by the unit-select value at 0x07.
// - Host writes an index to the pointer port, then uses the data port.
// - Bank registers are reachable only in the configuration state.
// - Bit 0 of 0x30 activates or deactivates the selected unit.
// - Unit 5 activate clears only on standby power-on reset.
// - A unit is on when its activate or power-control bit is set.
// - Activate and power-control bits are linked; changing one changes both.
// - Indices 0x31 to 0x5F are reserved: writes dropped, reads zero.
// - Indices 0x71, 0x73, 0x76 to 0xDF: writes dropped, reads zero.
// - Primary base: 0x60 holds bits 15..8, 0x61 bits 7..0.
// - Second base at 0x62 and 0x63 with the same byte split.
// - Base registers a unit does not use drop writes, read zero.
// - Base outside the permitted range blocks that unit's runtime access.
// - Every bank implements primary interrupt select at 0x70.
// - Primary interrupt select resets to 0x06 for unit 0, else zero.
// - Only the keyboard unit implements 0x72; elsewhere dropped, reads zero.
// - Unit interrupts are active-high edges after reset.
// - DMA select 0x74 only for floppy, serial 2, parallel; 0x75 always zero.
// - DMA select resets to 0x02 for unit 0, 0x04 for units 3 and 5.
// - Indices 0xE0 to 0xFE are vendor registers, none implemented here (writes dropped, reads zero); 0xFF is reserved.
// - Base decode uses address bits 11..0; 16-bit mode needs 15..12 zero.
// - Pointer port at the configuration address, data port one above.
`timescale 1ns/1ps
module lucb_top
  import lucb_pkg::*;
(
  // Clock and standby-supply power-on reset
  input  wire logic            clk,
  input  wire logic            rstn,
  // Other reset sources, same clock, active high
  input  wire logic            main_por,
  input  wire logic            hard_rst,
  input  wire logic            soft_rst,
  // Chip-level state
  input  wire logic            cfg_mode,
  input  wire logic [15:0]     cfg_port_addr,
  input  wire logic            qual16,
  // Host I/O cycle
  input  wire logic [15:0]     io_addr,
  input  wire logic            io_wr,
  input  wire logic            io_rd,
  input  wire logic [7:0]      io_wdata,
  output logic [7:0]           io_rdata,
  output logic                 io_rd_ack,
  // Power-control bit writes from the runtime block
  input  wire logic [7:0]      pwr_ctl_wr,
  input  wire logic [7:0]      pwr_ctl_val,
  // Per-unit results
  output logic [7:0]           unit_on,
  output logic [7:0]           unit_pwr_ctl,
  output logic [7:0]           unit_hit,
  output logic [7:0]           unit_base_ok,
  output logic [7:0][7:0]      unit_irq_sel,
  output logic [7:0][7:0]      unit_dma_sel,
  output logic                 irq_edge_high
);

  // Reset image of the whole state
  localparam lucb_state_s ST_RST = '{
    irq1:     IRQ1_RST,
    dma:      DMA_RST,
    irq_edge: 1'b1,
    default:  '0
  };

  lucb_state_s st_ff;
  lucb_state_s nxt_st;

  logic [15:0] data_addr;
  logic        idx_wr;
  logic        idx_rd;
  logic        dat_wr;
  logic        dat_rd;
  logic        bank_rst;
  logic [3:0]  slot_v;
  logic [2:0]  slot;
  logic        slot_ok;
  logic [7:0]  bank_rdata;
  logic [7:0]  hit_w;
  logic [7:0]  base_ok_w;

  // Port decode; nothing is reachable outside the configuration state
  assign data_addr = cfg_port_addr + DATA_PORT_OFS;
  assign idx_wr    = cfg_mode && io_wr && (io_addr == cfg_port_addr);
  assign idx_rd    = cfg_mode && io_rd && (io_addr == cfg_port_addr);
  assign dat_wr    = cfg_mode && io_wr && (io_addr == data_addr);
  assign dat_rd    = cfg_mode && io_rd && (io_addr == data_addr);
  assign bank_rst  = main_por || hard_rst || soft_rst;

  // Bank chosen by the live unit-select value
  assign slot_v  = lucb_slot(st_ff.unit_sel);
  assign slot    = slot_v[2:0];
  assign slot_ok = slot_v[3];

  // Read data of the selected bank
  lucb_bank_rd u_bank_rd (
    .slot     (slot),
    .index    (st_ff.index),
    .act      (st_ff.act[slot]),
    .base_hi  (st_ff.base_hi[slot]),
    .base_lo  (st_ff.base_lo[slot]),
    .base2_hi (st_ff.base2_hi[slot]),
    .base2_lo (st_ff.base2_lo[slot]),
    .irq1     (st_ff.irq1[slot]),
    .irq2     (st_ff.irq2[slot]),
    .dma      (st_ff.dma[slot]),
    .rdata    (bank_rdata)
  );

  // Runtime decode per unit; keyboard base is fixed, not programmable
  for (genvar g = 0; g < 8; g++) begin : g_match
    logic [15:0] base_w;
    assign base_w = (g == SLOT_KBD) ? KBD_BASE :
                    {st_ff.base_hi[g], st_ff.base_lo[g]};
    lucb_addr_match u_match (
      .base    (base_w),
      .active  (st_ff.act[g]),
      .rng_min (RNG_MIN[g]),
      .rng_max (RNG_MAX[g]),
      .rng_aln (RNG_ALN[g]),
      .qual16  (qual16),
      .io_addr (io_addr),
      .base_ok (base_ok_w[g]),
      .hit     (hit_w[g])
    );
  end

  // Next state
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rd_ack = 1'b0;
    nxt_st.hit    = hit_w & ~{8{cfg_mode}};
    nxt_st.base_ok = base_ok_w;

    // Soft, hard and main resets spare the serial 2 activate bit
    if (bank_rst) begin
      nxt_st = ST_RST;
      nxt_st.act[SLOT_SERIAL2] = st_ff.act[SLOT_SERIAL2];
      nxt_st.base_ok = base_ok_w;
    end else begin
      if (idx_wr) begin
        nxt_st.index = io_wdata;
      end
      if (dat_wr && (st_ff.index == IDX_UNIT_SEL)) begin
        nxt_st.unit_sel = io_wdata;
      end
      // Writes to absent or reserved indices fall through unused
      if (dat_wr && slot_ok && (st_ff.index >= IDX_BANK_LO)) begin
        case (st_ff.index)
          IDX_ACTIVATE: begin
            nxt_st.act[slot] = io_wdata[ACT_BIT];
          end
          IDX_BASE_HI: begin
            if (BASE1_MASK[slot]) begin
              nxt_st.base_hi[slot] = io_wdata;
            end
          end
          IDX_BASE_LO: begin
            if (BASE1_MASK[slot]) begin
              nxt_st.base_lo[slot] = io_wdata;
            end
          end
          IDX_BASE2_HI: begin
            if (BASE2_MASK[slot]) begin
              nxt_st.base2_hi[slot] = io_wdata;
            end
          end
          IDX_BASE2_LO: begin
            if (BASE2_MASK[slot]) begin
              nxt_st.base2_lo[slot] = io_wdata;
            end
          end
          IDX_IRQ1: begin
            nxt_st.irq1[slot] = io_wdata;
          end
          IDX_IRQ2: begin
            if (IRQ2_MASK[slot]) begin
              nxt_st.irq2[slot] = io_wdata;
            end
          end
          IDX_DMA: begin
            if (DMA_MASK[slot]) begin
              nxt_st.dma[slot] = io_wdata;
            end
          end
          default: begin
            nxt_st.index = nxt_st.index;
          end
        endcase
      end
      // Power-control writes land after host writes, so they win a tie
      for (int i = 0; i < 8; i++) begin
        if (pwr_ctl_wr[i]) begin
          nxt_st.act[i] = pwr_ctl_val[i];
        end
      end
    end

    // Reads answer one cycle later from the state before any same-cycle write
    if (idx_rd) begin
      nxt_st.rdata  = st_ff.index;
      nxt_st.rd_ack = 1'b1;
    end else if (dat_rd) begin
      nxt_st.rd_ack = 1'b1;
      if (st_ff.index == IDX_UNIT_SEL) begin
        nxt_st.rdata = st_ff.unit_sel;
      end else if (slot_ok && (st_ff.index >= IDX_BANK_LO)) begin
        nxt_st.rdata = bank_rdata;
      end else begin
        nxt_st.rdata = RD_ZERO;
      end
    end
  end

  // State register; rstn is the standby-supply power-on reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state flops
  assign io_rdata      = st_ff.rdata;
  assign io_rd_ack     = st_ff.rd_ack;
  assign unit_on       = st_ff.act;
  assign unit_pwr_ctl  = st_ff.act;
  assign unit_hit      = st_ff.hit;
  assign unit_base_ok  = st_ff.base_ok;
  assign unit_irq_sel  = st_ff.irq1;
  assign unit_dma_sel  = st_ff.dma;
  assign irq_edge_high = st_ff.irq_edge;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_idx_wr;
    idx_wr && !bank_rst;
  endsequence

  sequence s_bank_rd;
    dat_rd && !idx_wr && !dat_wr && !bank_rst && slot_ok;
  endsequence

  sequence s_bank_wr;
    dat_wr && slot_ok && !bank_rst;
  endsequence

  sequence s_quiet;
    !bank_rst && !dat_wr && (pwr_ctl_wr == 8'h00);
  endsequence

  index_write_a: assert property (s_idx_wr |=> st_ff.index == $past(io_wdata))
    else $error("index port write not taken");

  // Back-to-back reads are legal, so the pulse is judged cycle by cycle
  read_answer_a: assert property ((idx_rd || dat_rd) |=> io_rd_ack)
    else $error("read answer missing");

  no_ack_a: assert property (!(idx_rd || dat_rd) |=> !io_rd_ack)
    else $error("read answer without a read");

  unit_sel_wr_a: assert property (dat_wr && !bank_rst && (st_ff.index == IDX_UNIT_SEL)
                                  |=> st_ff.unit_sel == $past(io_wdata))
    else $error("unit select write not taken");

  cfg_gate_a: assert property ((s_quiet and !cfg_mode)
                               |=> $stable(st_ff.act) && $stable(st_ff.irq1))
    else $error("bank changed outside configuration state");

  activate_wr_a: assert property (dat_wr && slot_ok && !bank_rst && (pwr_ctl_wr == 8'h00)
                                  && (st_ff.index == IDX_ACTIVATE)
                                  |=> unit_on[$past(slot)] == $past(io_wdata[0]))
    else $error("activate write not applied to selected unit");

  serial2_keep_a: assert property ((soft_rst || hard_rst || main_por)
                                   && (pwr_ctl_wr == 8'h00)
                                   |=> $stable(st_ff.act[SLOT_SERIAL2]))
    else $error("serial 2 activate cleared by wrong reset");

  pwr_link_a: assert property ((pwr_ctl_wr != 8'h00) && !bank_rst
                               |=> (((unit_on ^ $past(pwr_ctl_val)) &
                                     $past(pwr_ctl_wr)) == 8'h00) &&
                                   (unit_pwr_ctl == unit_on))
    else $error("power-control write not mirrored");

  reserved_rd_a: assert property ((s_bank_rd and ((st_ff.index > IDX_ACTIVATE) &&
                                  (st_ff.index < IDX_BASE_HI)))
                                  |=> io_rd_ack && (io_rdata == RD_ZERO))
    else $error("reserved index read nonzero");

  unimpl_rd_a: assert property ((s_bank_rd and (st_ff.index > IDX_DMA))
                                |=> io_rd_ack && (io_rdata == RD_ZERO))
    else $error("unimplemented index read nonzero");

  irq2_absent_a: assert property ((s_bank_rd and ((st_ff.index == IDX_IRQ2) &&
                                  (slot != SLOT_KBD)))
                                  |=> io_rdata == RD_ZERO)
    else $error("secondary interrupt select visible on non-keyboard unit");

  dma_absent_a: assert property ((s_bank_rd and ((st_ff.index == IDX_DMA) && !DMA_MASK[slot]))
                                 |=> io_rdata == RD_ZERO)
    else $error("channel select visible on unit without one");

  base_wr_a: assert property ((s_bank_wr and ((st_ff.index == IDX_BASE_HI) && BASE1_MASK[slot]))
                              |=> st_ff.base_hi[$past(slot)] == $past(io_wdata))
    else $error("base high write not applied");

  base2_drop_a: assert property ((s_bank_wr and ((st_ff.index == IDX_BASE2_HI) &&
                                 !BASE2_MASK[slot]))
                                 |=> $stable(st_ff.base2_hi))
    else $error("unused second base took a write");

  irq1_wr_a: assert property ((s_bank_wr and (st_ff.index == IDX_IRQ1))
                              |=> unit_irq_sel[$past(slot)] == $past(io_wdata))
    else $error("primary interrupt select write not applied");

  defaults_a: assert property (soft_rst
                               |=> (unit_irq_sel[0] == IRQ1_RST[0]) &&
                                   (unit_dma_sel[0] == DMA_RST[0]) &&
                                   (unit_dma_sel[3] == DMA_RST[3]))
    else $error("reset defaults not restored");

  dma_default_a: assert property (main_por || hard_rst
                                  |=> (unit_dma_sel[1] == DMA_RST[1]) &&
                                      (unit_irq_sel[1] == IRQ1_RST[1]))
    else $error("unit 3 defaults not restored");

  act_clear_a: assert property (main_por || hard_rst || soft_rst
                                |=> (unit_on & ~(8'h01 << SLOT_SERIAL2)) == 8'h00)
    else $error("activate kept through bank reset");

  hit_gate_a: assert property ((unit_hit != 8'h00)
                               |-> (unit_hit & ~($past(base_ok_w) &
                                                 $past(st_ff.act))) == 8'h00)
    else $error("runtime hit with bad base or inactive unit");

  qual16_gate_a: assert property ((unit_hit != 8'h00)
                                  |-> !$past(qual16) ||
                                      ($past(io_addr[15:12]) == 4'h0))
    else $error("upper address bits ignored under 16-bit qualification");

  hit_cfg_a: assert property (cfg_mode |=> unit_hit == 8'h00)
    else $error("runtime hit during configuration state");

endmodule

/* File: dv/lucb_host_model.sv */
`timescale 1ns/1ps
module lucb_host_model
  import lucb_pkg::*;
(
  // Clock and pointer port address
  input  wire logic        clk,
  input  wire logic [15:0] port,
  // Host I/O cycle
  output logic [15:0]      io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic [7:0]       io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rd_ack
);
  // Idle bus shows the inverse of the last value, so stale data never matches
  initial begin
    io_addr  = 16'hFFFF;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'hFF;
  end

  // One strobe cycle, launched just after an edge, taken at the next edge
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_wr    = w;
    io_rd    = !w;
    @(posedge clk);
    #1;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask

  // Index first, then data one address above
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    cycle(port, idx, 1'b1);
    cycle(port + DATA_PORT_OFS, d, 1'b1);
  endtask

  // Answer is due exactly one cycle after the read edge
  task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d, output logic ok);
    cycle(port, idx, 1'b1);
    cycle(port + DATA_PORT_OFS, 8'h00, 1'b0);
    ok = (io_rd_ack === 1'b1);
    d  = io_rdata;
  endtask
endmodule

/* File: dv/test_logical_unit_config_bank.sv */
`timescale 1ns/1ps
module test_logical_unit_config_bank;
  import lucb_pkg::*;
  logic            clk, rstn, main_por, hard_rst, soft_rst, cfg_mode, qual16;
  logic            io_wr, io_rd, io_rd_ack, irq_edge_high, rd_ok;
  logic [15:0]     cfg_port_addr, io_addr;
  logic [7:0]      io_wdata, io_rdata, pwr_ctl_wr, pwr_ctl_val, rd_d;
  logic [7:0]      unit_on, unit_pwr_ctl, unit_hit, unit_base_ok;
  logic [7:0][7:0] unit_irq_sel, unit_dma_sel;
  int              mismatches, n_compared;
  // Unit number per slot, slot 7 in the top byte
  localparam logic [7:0][7:0] UNITS = 64'h0B0A_0907_0504_0300;
  localparam logic [19:0][7:0] DEAD = 160'h3137_383F_405F_6263_7172_7374_7576_A8A9_DFE0_FEFF;

  lucb_top dut (.clk(clk), .rstn(rstn), .main_por(main_por), .hard_rst(hard_rst),
    .soft_rst(soft_rst), .cfg_mode(cfg_mode), .cfg_port_addr(cfg_port_addr),
    .qual16(qual16), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack),
    .pwr_ctl_wr(pwr_ctl_wr), .pwr_ctl_val(pwr_ctl_val), .unit_on(unit_on),
    .unit_pwr_ctl(unit_pwr_ctl), .unit_hit(unit_hit), .unit_base_ok(unit_base_ok),
    .unit_irq_sel(unit_irq_sel), .unit_dma_sel(unit_dma_sel),
    .irq_edge_high(irq_edge_high));
  lucb_host_model host (.clk(clk), .port(cfg_port_addr), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rd_ack(io_rd_ack));

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Read with the acknowledge checked on the way
  task automatic rd(input logic [7:0] idx);
    host.cfg_rd(idx, rd_d, rd_ok);
    check({7'h00, rd_ok}, 8'h01, "read ack");
  endtask

  task automatic t_defaults();
    for (int i = 0; i < 8; i++) begin
      host.cfg_wr(IDX_UNIT_SEL, UNITS[i]);
      rd(IDX_IRQ1);
      check(rd_d, (i == 0) ? 8'h06 : 8'h00, "irq default");
      rd(IDX_DMA);
      check(rd_d, (i == 0) ? 8'h02 : (i == 1 || i == 3) ? 8'h04 : 8'h00, "dma");
      check(unit_irq_sel[i], (i == 0) ? 8'h06 : 8'h00, "irq port");
      check(unit_dma_sel[i], (i == 0) ? 8'h02 : (i == 1 || i == 3) ? 8'h04 : 8'h00, "dma port");
      rd(IDX_ACTIVATE);
      check(rd_d, 8'h00, "activate default");
    end
    check({7'h00, irq_edge_high}, 8'h01, "edge high");
    $display("test defaults done");
  endtask

  // Each unit's activate lands on its own slot only
  task automatic t_activate();
    for (int i = 0; i < 8; i++) begin
      host.cfg_wr(IDX_UNIT_SEL, UNITS[i]);
      host.cfg_wr(IDX_ACTIVATE, 8'h01);
      check(unit_on, 8'h01 << i, "unit on");
      check(unit_pwr_ctl, 8'h01 << i, "power linked");
      rd(IDX_ACTIVATE);
      check(rd_d, 8'h01, "activate readback");
      host.cfg_wr(IDX_ACTIVATE, 8'h00);
      check(unit_on, 8'h00, "unit off");
    end
    $display("test activate done");
  endtask

  task automatic pwr(input logic [7:0] val);
    @(posedge clk);
    #1;
    pwr_ctl_wr  = 8'h20;
    pwr_ctl_val = val;
    @(posedge clk);
    #1;
    pwr_ctl_wr  = 8'h00;
  endtask

  task automatic t_power();
    pwr(8'h20);
    check(unit_on, 8'h20, "power sets on");
    host.cfg_wr(IDX_UNIT_SEL, 8'h09);
    rd(IDX_ACTIVATE);
    check(rd_d, 8'h01, "activate follows");
    pwr(8'h00);
    check(unit_on | unit_pwr_ctl, 8'h00, "power clears");
    $display("test power done");
  endtask

  task automatic t_reserved();
    host.cfg_wr(IDX_UNIT_SEL, 8'h04);
    for (int i = 0; i < 20; i++) begin
      host.cfg_wr(DEAD[i], 8'hFF);
      rd(DEAD[i]);
      check(rd_d, 8'h00, "dead index");
    end
    host.cfg_wr(IDX_UNIT_SEL, 8'h05);
    host.cfg_wr(IDX_BASE2_HI, 8'h12);
    rd(IDX_BASE2_HI);
    check(rd_d, 8'h12, "second base");
    host.cfg_wr(IDX_UNIT_SEL, 8'h07);
    host.cfg_wr(IDX_IRQ2, 8'h05);
    rd(IDX_IRQ2);
    check(rd_d, 8'h05, "keyboard irq2");
    $display("test reserved done");
  endtask

  task automatic t_cfg_mode();
    cfg_mode = 1'b0;
    host.cfg_wr(IDX_ACTIVATE, 8'h01);
    check(unit_on, 8'h00, "closed write");
    host.cfg_rd(IDX_ACTIVATE, rd_d, rd_ok);
    check({7'h00, rd_ok}, 8'h00, "closed read");
    cfg_mode = 1'b1;
    $display("test cfg mode done");
  endtask

  // Runtime decode probe with configuration closed
  task automatic probe(input logic [15:0] a, input logic [7:0] exp);
    cfg_mode = 1'b0;
    host.cycle(a, 8'h00, 1'b0);
    check(unit_hit & 8'h04, exp, "decode");
    cfg_mode = 1'b1;
  endtask

  task automatic t_decode();
    host.cfg_wr(IDX_UNIT_SEL, 8'h04);
    host.cfg_wr(IDX_BASE_HI, 8'h03);
    host.cfg_wr(IDX_BASE_LO, 8'hF8);
    host.cfg_wr(IDX_ACTIVATE, 8'h01);
    rd(IDX_BASE_LO);
    check(rd_d, 8'hF8, "base low");
    check(unit_base_ok & 8'h04, 8'h04, "range ok");
    probe(16'h03F8, 8'h04);
    qual16 = 1'b1;
    probe(16'h13F8, 8'h00);
    qual16 = 1'b0;
    probe(16'h13F8, 8'h04);
    host.cfg_wr(IDX_BASE_HI, 8'h00);
    host.cfg_wr(IDX_BASE_LO, 8'h50);
    check(unit_base_ok & 8'h04, 8'h00, "range");
    probe(16'h0050, 8'h00);
    host.cfg_wr(IDX_ACTIVATE, 8'h00);
    $display("test decode done");
  endtask

  // Serial 2 activate survives every reset but the standby one
  task automatic t_resets();
    for (int k = 0; k < 3; k++) begin
      host.cfg_wr(IDX_UNIT_SEL, 8'h05);
      host.cfg_wr(IDX_ACTIVATE, 8'h01);
      host.cfg_wr(IDX_UNIT_SEL, 8'h00);
      host.cfg_wr(IDX_ACTIVATE, 8'h01);
      host.cfg_wr(IDX_IRQ1, 8'h03);
      {main_por, hard_rst, soft_rst} = 3'b001 << k;
      repeat (2) @(posedge clk);
      #1;
      {main_por, hard_rst, soft_rst} = 3'b000;
      repeat (2) @(posedge clk);
      #1;
      check(unit_on, 8'h08, "unit 5 held");
      check(unit_irq_sel[0], 8'h06, "irq reset");
    end
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    check(unit_on, 8'h00, "standby reset");
    $display("test resets done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    $display("BAD %0t run timed out", $time);
    end_sim();
  end

  initial begin
    {rstn, main_por, hard_rst, soft_rst, qual16} = 5'b00000;
    cfg_mode      = 1'b1;
    cfg_port_addr = 16'h002E;
    pwr_ctl_wr    = 8'h00;
    pwr_ctl_val   = 8'h00;
    mismatches    = 0;
    n_compared    = 0;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_defaults();
    t_activate();
    t_power();
    t_reserved();
    t_cfg_mode();
    t_decode();
    t_resets();
    end_sim();
  end
endmodule
